/* psc_board_model.sv */
// Board side of the shared clock-request pins: pull-up, wired-low resolution, downstream requests
`timescale 1ns/1ps
`default_nettype none

module psc_board_model (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] dev_req,
  output logic [3:0] pin_level
);
  // ==========================================================
  // Wire resolution
  // A low from either party wins; the board pull-up lifts a released line
  assign pin_level = ~dev_req & ~(pin_oe & ~pin_out);
endmodule

`default_nettype wire

/* psc_defines.svh */
// Register map, field positions, reset values and counts of the port strap configuration block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define PSC_ADDR_W 8
`define PSC_OFS_STRAP 8'h00
`define PSC_OFS_PRESENCE 8'h04
`define PSC_OFS_CLKREQ_CTRL 8'h08
`define PSC_OFS_CLKREQ_STAT 8'h0c
`define PSC_OFS_DEBUG_CTRL 8'h10

// ==========================================================
// Strap status register fields
`define PSC_STRAP_VC1_BIT 0
`define PSC_STRAP_RXDIS_BIT 1
`define PSC_STRAP_PL512_BIT 2
`define PSC_STRAP_CCLK_BIT 3
`define PSC_STRAP_SEL_BIT 4
`define PSC_STRAP_SLOT_LSB 5
`define PSC_STRAP_MPS_LSB 8
`define PSC_STRAP_LATCHED_BIT 11

// ==========================================================
// Clock request status fields
`define PSC_CRSTAT_REQ_LSB 0
`define PSC_CRSTAT_L1_LSB 4

// ==========================================================
// Debug control fields
`define PSC_DBG_VALUE_LSB 0
`define PSC_DBG_SRC_BIT 4

// ==========================================================
// Reset values
`define PSC_CLKREQ_CTRL_RST 4'hf
`define PSC_DEBUG_CTRL_RST 5'h00

// ==========================================================
// Payload capability encodings
`define PSC_MPS_256 3'h1
`define PSC_MPS_512 3'h2

// ==========================================================
// Counts
`define PSC_SYNC_W 15
`define PSC_SETTLE_CYCLES 2'h3

`endif

/* psc_pkg.sv */
// Types shared by the port strap configuration block
package psc_pkg;

  typedef enum logic [0:0] {
    PSC_SETTLE = 1'b0,
    PSC_LATCHED = 1'b1
  } psc_state_t;

  typedef enum logic [1:0] {
    PSC_HTRANS_IDLE = 2'b00,
    PSC_HTRANS_BUSY = 2'b01,
    PSC_HTRANS_NONSEQ = 2'b10,
    PSC_HTRANS_SEQ = 2'b11
  } psc_htrans_t;

  typedef logic [2:0] psc_mps_t;

endpackage

/* psc_sync.sv */
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module psc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // ==========================================================
  // One pair of flip-flops per bit; only stage two reads stage one
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* psc_top.sv */
// Port strap configuration block with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"

// Function
// - Second-channel strap high: channel 1 active, no shared buffers.
// - Second-channel strap low: channel 1 off, its buffers go to channel 0.
// - Polarity-detect disable strap high turns detection off; low turns it on.
// - Large-payload strap high reports 512 byte capability, low reports 256.
// - Low presence input on ports 1 to 3 means card present.
// - Common slot clock strap high means platform reference clock is shared.
// - Slot-fitted strap set means slot, otherwise direct chip-to-chip link.
// - Select strap low: shared pins are active-low clock requests.
// - Request released: clock and PLL off, port enters L1 substate.
// - Select strap high: shared pins drive per-port debug status.
module psc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic second_channel_enable_strap,
  input wire logic rx_polarity_detect_disable,
  input wire logic large_payload_strap,
  input wire logic common_slot_clock_strap,
  input wire logic substate_or_status_select,
  input wire logic [3:1] slot_fitted_strap,
  input wire logic [3:1] card_presence_n,
  input wire logic [3:0] refclk_request_n_in,
  output logic [3:0] refclk_request_n_out,
  output logic [3:0] refclk_request_n_oe,
  input wire logic [3:0] port_link_status,
  output logic vc1_active,
  output logic vc0_shared_buffers,
  output logic rx_polarity_detect_en,
  output psc_pkg::psc_mps_t max_payload_code,
  output logic common_clock_cfg,
  output logic [3:1] slot_fitted,
  output logic [3:1] card_present,
  output logic [3:0] refclk_enable,
  output logic [3:0] pll_enable,
  output logic [3:0] l1_substate
);
  import psc_pkg::*;

  // ==========================================================
  // Pin synchronisation
  logic [`PSC_SYNC_W-1:0] pins_raw;
  logic [`PSC_SYNC_W-1:0] pins_sync;
  logic s_vc1;
  logic s_rxdis;
  logic s_pl512;
  logic s_cclk;
  logic s_sel;
  logic [3:1] s_slot;
  logic [3:1] s_presence_n;
  logic [3:0] s_req_n;

  assign pins_raw = {refclk_request_n_in, card_presence_n, slot_fitted_strap, substate_or_status_select,
                     common_slot_clock_strap, large_payload_strap, rx_polarity_detect_disable,
                     second_channel_enable_strap};
  assign {s_req_n, s_presence_n, s_slot, s_sel, s_cclk, s_pl512, s_rxdis, s_vc1} = pins_sync;

  psc_sync #(
    .W(`PSC_SYNC_W)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // ==========================================================
  // Strap capture after reset release
  // Async reset may only load constants, so the straps are caught by the
  // clock once the synchroniser has filled, then frozen until next reset.
  psc_state_t state;
  psc_state_t next_state;
  logic [1:0] settle_cnt;
  logic strap_vc1;
  logic strap_rxdis;
  logic strap_pl512;
  logic strap_cclk;
  logic strap_sel;
  logic [3:1] strap_slot;
  logic latched;
  logic l1_mode;
  logic status_mode;

  always_comb begin
    next_state = state;
    unique case (state)
      PSC_SETTLE: begin
        if (settle_cnt == `PSC_SETTLE_CYCLES - 2'h1) begin
          next_state = PSC_LATCHED;
        end
      end
      PSC_LATCHED: begin
        next_state = PSC_LATCHED;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PSC_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= 2'h0;
    end else if (state == PSC_SETTLE) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_vc1 <= 1'b0;
      strap_rxdis <= 1'b0;
      strap_pl512 <= 1'b0;
      strap_cclk <= 1'b0;
      strap_sel <= 1'b0;
      strap_slot <= 3'h0;
    end else if (state == PSC_SETTLE) begin
      strap_vc1 <= s_vc1;
      strap_rxdis <= s_rxdis;
      strap_pl512 <= s_pl512;
      strap_cclk <= s_cclk;
      strap_sel <= s_sel;
      strap_slot <= s_slot;
    end
  end

  assign latched = (state == PSC_LATCHED);
  assign l1_mode = latched && !strap_sel;
  assign status_mode = latched && strap_sel;

  // ==========================================================
  // Configuration outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vc1_active <= 1'b0;
      vc0_shared_buffers <= 1'b0;
    end else begin
      vc1_active <= latched && strap_vc1;
      vc0_shared_buffers <= latched && !strap_vc1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_polarity_detect_en <= 1'b0;
      max_payload_code <= `PSC_MPS_256;
    end else begin
      rx_polarity_detect_en <= latched && !strap_rxdis;
      max_payload_code <= (latched && strap_pl512) ? `PSC_MPS_512 : `PSC_MPS_256;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      common_clock_cfg <= 1'b0;
      slot_fitted <= 3'h0;
    end else begin
      common_clock_cfg <= latched && strap_cclk;
      slot_fitted <= latched ? strap_slot : 3'h0;
    end
  end

  // Presence is not frozen: cards may come and go at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_present <= 3'h0;
    end else begin
      card_present <= ~s_presence_n;
    end
  end

  // ==========================================================
  // Shared pins: clock requests or debug status
  logic [3:0] clkreq_ctrl;
  logic [4:0] debug_ctrl;
  logic [3:0] req_seen;
  logic [3:0] status_value;

  assign req_seen = ~s_req_n;
  assign status_value = debug_ctrl[`PSC_DBG_SRC_BIT] ? debug_ctrl[3:0] : port_link_status;

  // Open-drain in request mode: pull low to ask for the clock, else release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refclk_request_n_out <= 4'h0;
      refclk_request_n_oe <= 4'h0;
    end else if (status_mode) begin
      refclk_request_n_out <= status_value;
      refclk_request_n_oe <= 4'hf;
    end else begin
      refclk_request_n_out <= 4'h0;
      refclk_request_n_oe <= l1_mode ? clkreq_ctrl : 4'h0;
    end
  end

  // Outside request mode the clock stays on; the pin is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refclk_enable <= 4'hf;
      pll_enable <= 4'hf;
      l1_substate <= 4'h0;
    end else begin
      refclk_enable <= ~({4{l1_mode}} & ~req_seen);
      pll_enable <= ~({4{l1_mode}} & ~req_seen);
      l1_substate <= {4{l1_mode}} & ~req_seen;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic acc;
  logic wr_pend;
  logic [`PSC_ADDR_W-1:0] wr_addr;
  logic [31:0] next_rdata;

  assign acc = hsel && hready && (htrans == PSC_HTRANS_NONSEQ || htrans == PSC_HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite && (haddr[31:`PSC_ADDR_W] == 24'h000000);
      wr_addr <= haddr[`PSC_ADDR_W-1:0];
    end
  end

  // Only the low bits are decoded beyond the 256-byte window check; hsize is
  // not checked since the master only issues whole words
  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[31:`PSC_ADDR_W] == 24'h000000) begin
      case (haddr[`PSC_ADDR_W-1:0])
        `PSC_OFS_STRAP: begin
          next_rdata[`PSC_STRAP_VC1_BIT] = strap_vc1;
          next_rdata[`PSC_STRAP_RXDIS_BIT] = strap_rxdis;
          next_rdata[`PSC_STRAP_PL512_BIT] = strap_pl512;
          next_rdata[`PSC_STRAP_CCLK_BIT] = strap_cclk;
          next_rdata[`PSC_STRAP_SEL_BIT] = strap_sel;
          next_rdata[`PSC_STRAP_SLOT_LSB +: 3] = strap_slot;
          next_rdata[`PSC_STRAP_MPS_LSB +: 3] = max_payload_code;
          next_rdata[`PSC_STRAP_LATCHED_BIT] = latched;
        end
        `PSC_OFS_PRESENCE: begin
          next_rdata[3:1] = card_present;
        end
        `PSC_OFS_CLKREQ_CTRL: begin
          next_rdata[3:0] = clkreq_ctrl;
        end
        `PSC_OFS_CLKREQ_STAT: begin
          next_rdata[`PSC_CRSTAT_REQ_LSB +: 4] = req_seen;
          next_rdata[`PSC_CRSTAT_L1_LSB +: 4] = l1_substate;
        end
        `PSC_OFS_DEBUG_CTRL: begin
          next_rdata[4:0] = debug_ctrl;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clkreq_ctrl <= `PSC_CLKREQ_CTRL_RST;
    end else if (wr_pend && wr_addr == `PSC_OFS_CLKREQ_CTRL) begin
      clkreq_ctrl <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_ctrl <= `PSC_DEBUG_CTRL_RST;
    end else if (wr_pend && wr_addr == `PSC_OFS_DEBUG_CTRL) begin
      debug_ctrl <= hwdata[4:0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_req_released;
    (l1_mode && refclk_request_n_in[0]) [*3];
  endsequence

  sequence s_req_asserted;
    (l1_mode && !refclk_request_n_in[0]) [*3];
  endsequence

  a_vc1_on: assert property (latched && strap_vc1 |=> vc1_active && !vc0_shared_buffers)
    else $error("second channel not active with strap high");
  a_vc1_off: assert property (latched && !strap_vc1 |=> !vc1_active && vc0_shared_buffers)
    else $error("second channel not disabled with strap low");
  a_polarity_detect: assert property (latched |=> rx_polarity_detect_en == !$past(strap_rxdis))
    else $error("polarity detect enable does not follow strap");
  a_payload_code: assert property (latched |=> max_payload_code == ($past(strap_pl512) ? 3'h2 : 3'h1))
    else $error("payload capability code wrong");
  a_presence_follow: assert property (latched |-> card_present == ~$past(card_presence_n, 3))
    else $error("presence not followed after three cycles");
  a_slot_clock: assert property (latched |=> common_clock_cfg == $past(strap_cclk))
    else $error("common clock indication wrong");
  a_slot_fitted: assert property (latched |=> slot_fitted == $past(strap_slot))
    else $error("slot fitted indication wrong");
  a_req_drive: assert property (l1_mode |=> refclk_request_n_out == 4'h0 && refclk_request_n_oe == $past(clkreq_ctrl))
    else $error("request pin not driven open-drain");
  a_l1_enter: assert property (s_req_released |=> l1_substate[0] && !refclk_enable[0] && !pll_enable[0])
    else $error("port did not enter substate on released request");
  a_l1_exit: assert property (s_req_asserted |=> !l1_substate[0] && refclk_enable[0] && pll_enable[0])
    else $error("port did not leave substate on asserted request");
  a_status_out: assert property (status_mode |=> refclk_request_n_oe == 4'hf)
    else $error("status pins not driven");
  a_straps_frozen: assert property (latched |=> $stable({strap_vc1, strap_rxdis, strap_pl512, strap_sel}))
    else $error("latched straps changed");

endmodule

`default_nettype wire

/* psc_top_tb_top.sv */
// Self-checking bench for the port strap configuration block
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"

module psc_top_tb_top;
  import psc_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic [7:0] straps;
  logic [3:1] card_presence_n, slot_fitted, card_present;
  logic [3:0] dev_req, port_link_status, pin_level, pin_out, pin_oe;
  logic [3:0] refclk_enable, pll_enable, l1_substate;
  logic vc1_active, vc0_shared_buffers, rx_polarity_detect_en, common_clock_cfg;
  psc_mps_t max_payload_code;
  int errors = 0;
  int checks = 0;

  psc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .second_channel_enable_strap(straps[0]),
    .rx_polarity_detect_disable(straps[1]), .large_payload_strap(straps[2]),
    .common_slot_clock_strap(straps[3]), .substate_or_status_select(straps[4]),
    .slot_fitted_strap(straps[7:5]), .card_presence_n(card_presence_n),
    .refclk_request_n_in(pin_level), .refclk_request_n_out(pin_out), .refclk_request_n_oe(pin_oe),
    .port_link_status(port_link_status), .vc1_active(vc1_active),
    .vc0_shared_buffers(vc0_shared_buffers), .rx_polarity_detect_en(rx_polarity_detect_en),
    .max_payload_code(max_payload_code), .common_clock_cfg(common_clock_cfg),
    .slot_fitted(slot_fitted), .card_present(card_present), .refclk_enable(refclk_enable),
    .pll_enable(pll_enable), .l1_substate(l1_substate));

  psc_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .dev_req(dev_req), .pin_level(pin_level));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ==========================================================
  // Checking and verdict
  task automatic print_verdict;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_strap(input logic [7:0] s);
    return {20'h0, 1'b1, (s[2] ? `PSC_MPS_512 : `PSC_MPS_256), s};
  endfunction

  // ==========================================================
  // Bus master
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errors++;
      print_verdict;
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= PSC_HTRANS_NONSEQ;
    wait_ready();
    htrans <= PSC_HTRANS_IDLE;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    cmp(hresp, 32'h0);
  endtask

  task automatic rd_cmp(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    cmp(rd, exp);
  endtask

  task automatic strap_reset(input logic [7:0] s);
    @(posedge hclk);
    straps <= s;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  task automatic check_cfg(input logic [7:0] s);
    cmp(vc1_active, s[0]);
    cmp(vc0_shared_buffers, !s[0]);
    cmp(rx_polarity_detect_en, !s[1]);
    cmp(max_payload_code, s[2] ? `PSC_MPS_512 : `PSC_MPS_256);
    cmp(common_clock_cfg, s[3]);
    cmp(slot_fitted, s[7:5]);
    rd_cmp(`PSC_OFS_STRAP, exp_strap(s));
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] s;
    logic [3:0] c, a, lnk;
    logic [4:0] dbg;
    logic [31:0] rd;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = PSC_HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    straps = 8'h00;
    card_presence_n = 3'h7;
    dev_req = 4'h0;
    port_link_status = 4'h0;
    void'($urandom(32'hfd59));
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      strap_reset(s);
      check_cfg(s);
      straps <= ~s;
      repeat (6) @(posedge hclk);
      check_cfg(s);
      ahb(1'b1, `PSC_OFS_STRAP, 32'hffffffff, rd);
      rd_cmp(`PSC_OFS_STRAP, exp_strap(s));
      rd_cmp(32'h40, 32'h0);
      rd_cmp(32'h104, 32'h0);
      card_presence_n <= 3'($urandom);
      repeat (5) @(posedge hclk);
      cmp(card_present, 3'(~card_presence_n));
      rd_cmp(`PSC_OFS_PRESENCE, {28'h0, ~card_presence_n, 1'b0});
      rd_cmp(`PSC_OFS_DEBUG_CTRL, 32'h0);
      if (!s[4]) begin
        rd_cmp(`PSC_OFS_CLKREQ_CTRL, 32'hf);
        cmp(refclk_enable, 4'hf);
        for (int j = 0; j < 5; j++) begin
          c = (j < 2) ? 4'h0 : 4'($urandom);
          dev_req <= (j == 0) ? 4'h0 : (j == 1) ? 4'hf : 4'($urandom);
          ahb(1'b1, `PSC_OFS_CLKREQ_CTRL, {28'h0, c}, rd);
          repeat (5) @(posedge hclk);
          a = dev_req | c;
          cmp(pin_oe, c);
          cmp(pin_out & pin_oe, 4'h0);
          cmp(l1_substate, 4'(~a));
          cmp(refclk_enable, a);
          cmp(pll_enable, a);
          rd_cmp(`PSC_OFS_CLKREQ_STAT, {24'h0, ~a, a});
        end
        dev_req <= 4'h0;
      end else begin
        for (int j = 0; j < 4; j++) begin
          lnk = 4'($urandom);
          dbg = {j[0], 4'($urandom)};
          port_link_status <= lnk;
          ahb(1'b1, `PSC_OFS_DEBUG_CTRL, {27'h0, dbg}, rd);
          repeat (3) @(posedge hclk);
          cmp(pin_oe, 4'hf);
          cmp(pin_out, dbg[4] ? dbg[3:0] : lnk);
          cmp(pin_level, pin_out);
          rd_cmp(`PSC_OFS_DEBUG_CTRL, {27'h0, dbg});
        end
      end
    end
    print_verdict;
  end
endmodule

`default_nettype wire
